// >>> logic/slmc_pkg.sv
// Functional notes
// - sample both strap inputs at power-up
// - software may read and overwrite strap bits
// - first strap: four levels to two bits
// - second strap: eight levels to three bits
// - source 0 remote-then-internal, 1 external local
// - audio bit adds auxiliary channel when set
// - external control bit hands control to bus pins
// - cable bit selects twisted pair or cable_type_select
// - copy remote display id into sram when set
// - strap bits land in 0x4f, 0x54 and 0x5b
// - cable and copy bits land in 0x5b, 0x54
// - single link limits 96 mhz, legacy receiver below 85 mhz
// - forced single disables secondary phy and back channel
// - dual splits alternate pixels, half clock, 170 mhz
// - dual link uses one protected connection
// - dual automatic when capable and fast enough
// - replicate uses second protection core, 85 mhz
// - mode chosen from capabilities and pixel clock
// - two receivers replicate, secondary alone allowed
// - auto-detect can be disabled for forced mode
// - frequency change may reset serial pll when enabled
package slmc_pkg;
    localparam int CLK_PERIOD_NS = 20;
    localparam int STRAP_SETTLE_NS = 10000;
    localparam int STRAP_SETTLE_CYC = (STRAP_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [9:0] IDX_BRIDGE_CONTROL = 10'h04f;
    localparam logic [9:0] IDX_BRIDGE_CONFIGURATION = 10'h054;
    localparam logic [9:0] IDX_DUAL_LINK_CONTROL = 10'h05b;
    localparam logic [9:0] IDX_LINK_STATUS = 10'h060;
    localparam logic [9:0] IDX_DISPLAY_ID_ADDRESS = 10'h061;
    localparam int BIT_DISPLAY_ID_DISABLE = 0;
    localparam int BIT_AUDIO_AUX = 1;
    localparam int BIT_REMOTE_COPY = 5;
    localparam int BIT_EXTERNAL_CONTROL = 7;
    localparam int BIT_AUTO_DISABLE = 0;
    localparam int BIT_FORCED_MODE_LO = 1;
    localparam int BIT_PLL_RESET_FREQ = 5;
    localparam int BIT_COAXIAL_CABLE = 7;
    localparam logic [7:0] RST_BRIDGE_CONTROL = 8'h00;
    localparam logic [7:0] RST_BRIDGE_CONFIGURATION = 8'h00;
    localparam logic [7:0] RST_DUAL_LINK_CONTROL = 8'h20;
    localparam logic [7:0] RST_DISPLAY_ID_ADDRESS = 8'ha0;
    localparam logic [7:0] SINGLE_MAX_MHZ = 8'd96;
    localparam logic [7:0] LEGACY_MAX_MHZ = 8'd85;
    localparam logic [7:0] DUAL_MIN_MHZ = 8'd97;
    localparam logic [7:0] DUAL_MAX_MHZ = 8'd170;
    localparam logic [7:0] REPLICATE_MAX_MHZ = 8'd85;
    // strap ratio codes are ratio * 255; thresholds sit halfway between levels
    localparam logic [6:0][7:0] STRAP0_THR = {8'hff, 8'hff, 8'hff, 8'hff, 8'h9b, 8'h61, 8'h1a};
    localparam logic [6:0][7:0] STRAP1_THR = {8'he4, 8'hb9, 8'h9b, 8'h7e, 8'h61, 8'h43, 8'h1a};
    localparam logic [1:0] FORCE_SINGLE = 2'h0;
    localparam logic [1:0] FORCE_DUAL = 2'h1;
    localparam logic [1:0] FORCE_REPLICATE = 2'h2;
    typedef enum logic [1:0] {LINK_SINGLE, LINK_DUAL, LINK_REPLICATE, LINK_SECONDARY_ONLY} slmc_link_mode_type;

    function automatic logic [2:0] slmc_level(input logic [7:0] code, input logic [6:0][7:0] thr);
        logic [2:0] n;
        n = 3'h0;
        for (int i = 0; i < 7; i++) begin
            if (thr[i] != 8'hff && code >= thr[i]) begin
                n = n + 3'h1;
            end
        end
        return n;
    endfunction
endpackage

// >>> logic/slmc_cfg_if.sv
`timescale 1ns/100ps
interface slmc_cfg_if;
    import slmc_pkg::*;
    logic strap_load;
    logic [4:0] strap_bits;
    logic auto_disable;
    logic [1:0] forced_mode;
    logic [7:0] freq_mhz;
    logic rx0_present;
    logic rx1_present;
    logic rx0_dual_capable;
    logic rx0_legacy;
    slmc_link_mode_type mode;
    logic over_speed;
    modport strap (output strap_load, output strap_bits);
    modport regs (input strap_load, input strap_bits, input mode, input over_speed, output auto_disable,
                  output forced_mode, output freq_mhz, output rx0_present, output rx1_present,
                  output rx0_dual_capable, output rx0_legacy);
    modport sel (input auto_disable, input forced_mode, input freq_mhz, input rx0_present, input rx1_present,
                 input rx0_dual_capable, input rx0_legacy, output mode, output over_speed);
endinterface

// >>> logic/slmc_strap_sampler.sv
`timescale 1ns/100ps
module slmc_strap_sampler import slmc_pkg::*; (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [7:0] first_config_strap,
    input wire logic [7:0] second_config_strap,
    slmc_cfg_if.strap cfg
);
    logic [15:0] settle_q;
    logic done_q;
    logic load_q;
    logic [4:0] bits_q;
    wire [2:0] lvl0 = slmc_level(first_config_strap, STRAP0_THR);
    wire [2:0] lvl1 = slmc_level(second_config_strap, STRAP1_THR);
    wire settled = (settle_q == 16'(STRAP_SETTLE_CYC - 1));

    // pins are read once after release, so they may later serve other uses
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            settle_q <= 16'h0000;
            done_q <= 1'b0;
            load_q <= 1'b0;
            bits_q <= 5'h00;
        end else begin
            load_q <= 1'b0;
            if (!done_q) begin
                if (settled) begin
                    done_q <= 1'b1;
                    load_q <= 1'b1;
                    bits_q <= {lvl0[1:0], lvl1};
                end else begin
                    settle_q <= settle_q + 16'h0001;
                end
            end
        end
    end

    assign cfg.strap_load = load_q;
    assign cfg.strap_bits = bits_q;
endmodule

// >>> logic/slmc_link_mode_select.sv
`timescale 1ns/100ps
module slmc_link_mode_select import slmc_pkg::*; (
    input wire logic pclk,
    input wire logic presetn,
    slmc_cfg_if.sel cfg
);
    slmc_link_mode_type auto_mode;
    slmc_link_mode_type forced;
    slmc_link_mode_type next_mode;
    slmc_link_mode_type mode_q;
    logic over_q;

    wire dual_ok = cfg.rx0_dual_capable && cfg.freq_mhz >= DUAL_MIN_MHZ;
    wire both = cfg.rx0_present && cfg.rx1_present;
    assign auto_mode = both ? LINK_REPLICATE :
                       (!cfg.rx0_present && cfg.rx1_present) ? LINK_SECONDARY_ONLY :
                       (cfg.rx0_present && dual_ok) ? LINK_DUAL : LINK_SINGLE;
    assign forced = (cfg.forced_mode == FORCE_DUAL) ? LINK_DUAL :
                    (cfg.forced_mode == FORCE_REPLICATE) ? LINK_REPLICATE : LINK_SINGLE;
    assign next_mode = cfg.auto_disable ? forced : auto_mode;
    wire single_lim = cfg.rx0_legacy ? (cfg.freq_mhz >= LEGACY_MAX_MHZ) : (cfg.freq_mhz > SINGLE_MAX_MHZ);
    wire over_d = (next_mode == LINK_DUAL) ? (cfg.freq_mhz > DUAL_MAX_MHZ) :
                  (next_mode == LINK_REPLICATE) ? (cfg.freq_mhz > REPLICATE_MAX_MHZ) : single_lim;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_q <= LINK_SINGLE;
            over_q <= 1'b0;
        end else begin
            mode_q <= next_mode;
            over_q <= over_d;
        end
    end

    assign cfg.mode = mode_q;
    assign cfg.over_speed = over_q;
endmodule

// >>> logic/slmc_strap_link_config.sv
`timescale 1ns/100ps
module slmc_strap_link_config import slmc_pkg::*; (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [7:0] first_config_strap,
    input wire logic [7:0] second_config_strap,
    input wire logic rx0_present,
    input wire logic rx1_present,
    input wire logic rx0_dual_capable,
    input wire logic rx0_legacy,
    input wire logic [7:0] pixel_clock_mhz,
    input wire logic freq_change_detected,
    input wire logic remote_display_id_found,
    output logic use_remote_display_id,
    output logic use_external_local_display_id,
    output logic [7:0] remote_display_id_address,
    output logic copy_remote_to_sram,
    output logic aux_audio_enable,
    output logic external_controller_override,
    output logic cable_type_select,
    output logic [1:0] link_mode,
    output logic primary_tx_enable,
    output logic secondary_tx_enable,
    output logic secondary_back_channel_enable,
    output logic pixel_split_enable,
    output logic tx_clock_half_rate,
    output logic shared_protection_session,
    output logic second_protection_core_enable,
    output logic serial_pll_reset,
    output logic pixel_clock_over_limit
);
    slmc_cfg_if cfg ();

    logic [7:0] bridge_control_q;
    logic [7:0] bridge_control_d;
    logic [7:0] bridge_configuration_q;
    logic [7:0] bridge_configuration_d;
    logic [7:0] dual_link_control_q;
    logic [7:0] dual_link_control_d;
    logic [7:0] display_id_address_q;
    logic [7:0] display_id_address_d;
    logic strap_loaded_q;
    logic [31:0] prdata_q;
    logic [31:0] rdata_d;
    logic slverr_q;
    logic pll_reset_q;
    logic [1:0] link_mode_q;
    logic primary_tx_q;
    logic secondary_tx_q;
    logic back_channel_q;
    logic split_q;
    logic shared_prot_q;
    logic second_core_q;
    logic over_q;
    logic [7:0] status_byte;

    slmc_strap_sampler u_strap (
        .pclk(pclk),
        .presetn(presetn),
        .first_config_strap(first_config_strap),
        .second_config_strap(second_config_strap),
        .cfg(cfg.strap)
    );

    slmc_link_mode_select u_mode (
        .pclk(pclk),
        .presetn(presetn),
        .cfg(cfg.sel)
    );

    function automatic logic addr_is(input logic [11:0] addr, input logic [9:0] idx);
        return addr == {idx, 2'b00};
    endfunction

    // apb decode: zero wait states, read data captured in the setup cycle
    wire setup_phase = psel && !penable;
    wire access_phase = psel && penable;
    wire hit_ctl = addr_is(paddr, IDX_BRIDGE_CONTROL);
    wire hit_cfg = addr_is(paddr, IDX_BRIDGE_CONFIGURATION);
    wire hit_dual = addr_is(paddr, IDX_DUAL_LINK_CONTROL);
    wire hit_stat = addr_is(paddr, IDX_LINK_STATUS);
    wire hit_addr = addr_is(paddr, IDX_DISPLAY_ID_ADDRESS);
    wire mapped = hit_ctl || hit_cfg || hit_dual || hit_stat || hit_addr;
    wire wr_en = access_phase && pwrite && mapped;
    wire wr_ctl = wr_en && hit_ctl;
    wire wr_cfg = wr_en && hit_cfg;
    wire wr_dual = wr_en && hit_dual;
    wire wr_addr = wr_en && hit_addr;

    // strap bits in the sampler's packing
    wire strap_edid = cfg.strap_bits[4];
    wire strap_aux = cfg.strap_bits[3];
    wire strap_ext = cfg.strap_bits[2];
    wire strap_cable_type_select = cfg.strap_bits[1];
    wire strap_copy = cfg.strap_bits[0];

    // a software write in the load cycle wins, so the register setting is never lost
    always_comb begin
        bridge_control_d = bridge_control_q;
        if (wr_ctl) begin
            bridge_control_d = pwdata[7:0];
        end else if (cfg.strap_load) begin
            bridge_control_d[BIT_DISPLAY_ID_DISABLE] = strap_edid;
        end
    end

    always_comb begin
        bridge_configuration_d = bridge_configuration_q;
        if (wr_cfg) begin
            bridge_configuration_d = pwdata[7:0];
        end else if (cfg.strap_load) begin
            bridge_configuration_d[BIT_AUDIO_AUX] = strap_aux;
            bridge_configuration_d[BIT_EXTERNAL_CONTROL] = strap_ext;
            bridge_configuration_d[BIT_REMOTE_COPY] = strap_copy;
        end
    end

    always_comb begin
        dual_link_control_d = dual_link_control_q;
        if (wr_dual) begin
            dual_link_control_d = pwdata[7:0];
        end else if (cfg.strap_load) begin
            dual_link_control_d[BIT_COAXIAL_CABLE] = strap_cable_type_select;
        end
    end

    always_comb begin
        display_id_address_d = display_id_address_q;
        if (wr_addr) begin
            display_id_address_d = pwdata[7:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bridge_control_q <= RST_BRIDGE_CONTROL;
            bridge_configuration_q <= RST_BRIDGE_CONFIGURATION;
            dual_link_control_q <= RST_DUAL_LINK_CONTROL;
            display_id_address_q <= RST_DISPLAY_ID_ADDRESS;
        end else begin
            bridge_control_q <= bridge_control_d;
            bridge_configuration_q <= bridge_configuration_d;
            dual_link_control_q <= dual_link_control_d;
            display_id_address_q <= display_id_address_d;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            strap_loaded_q <= 1'b0;
        end else if (cfg.strap_load) begin
            strap_loaded_q <= 1'b1;
        end
    end

    // control fields handed to the mode selector
    assign cfg.auto_disable = dual_link_control_q[BIT_AUTO_DISABLE];
    assign cfg.forced_mode = dual_link_control_q[BIT_FORCED_MODE_LO +: 2];
    assign cfg.freq_mhz = pixel_clock_mhz;
    assign cfg.rx0_present = rx0_present;
    assign cfg.rx1_present = rx1_present;
    assign cfg.rx0_dual_capable = rx0_dual_capable;
    assign cfg.rx0_legacy = rx0_legacy;

    assign status_byte = {2'b00, strap_loaded_q, rx1_present, rx0_present, cfg.over_speed, cfg.mode};

    always_comb begin
        rdata_d = 32'h0000_0000;
        if (hit_ctl) begin
            rdata_d[7:0] = bridge_control_q;
        end else if (hit_cfg) begin
            rdata_d[7:0] = bridge_configuration_q;
        end else if (hit_dual) begin
            rdata_d[7:0] = dual_link_control_q;
        end else if (hit_stat) begin
            rdata_d[7:0] = status_byte;
        end else if (hit_addr) begin
            rdata_d[7:0] = display_id_address_q;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q <= 32'h0000_0000;
            slverr_q <= 1'b0;
        end else if (setup_phase) begin
            prdata_q <= pwrite ? 32'h0000_0000 : rdata_d;
            slverr_q <= !mapped;
        end
    end

    assign prdata = prdata_q;
    assign pready = 1'b1;
    assign pslverr = access_phase && slverr_q;

    // option bits to the rest of the bridge
    wire display_id_source_select = bridge_control_q[BIT_DISPLAY_ID_DISABLE];
    wire copy_sel = bridge_configuration_q[BIT_REMOTE_COPY];
    wire mode_dual = (cfg.mode == LINK_DUAL);
    wire mode_rep = (cfg.mode == LINK_REPLICATE);
    wire mode_sec = (cfg.mode == LINK_SECONDARY_ONLY);
    // forced single reaches here through the selected mode, so link_mode and the enables move together
    // a spurious pll reset can drop lock downstream; the enable is set at reset (0x20)
    wire pll_reset_d = freq_change_detected && dual_link_control_q[BIT_PLL_RESET_FREQ];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            link_mode_q <= 2'b00;
            primary_tx_q <= 1'b0;
            secondary_tx_q <= 1'b0;
            back_channel_q <= 1'b0;
            split_q <= 1'b0;
            shared_prot_q <= 1'b0;
            second_core_q <= 1'b0;
            over_q <= 1'b0;
            pll_reset_q <= 1'b0;
        end else begin
            link_mode_q <= cfg.mode;
            primary_tx_q <= !mode_sec;
            secondary_tx_q <= mode_dual || mode_rep || mode_sec;
            back_channel_q <= mode_dual || mode_rep || mode_sec;
            split_q <= mode_dual;
            shared_prot_q <= mode_dual;
            second_core_q <= mode_rep;
            over_q <= cfg.over_speed;
            pll_reset_q <= pll_reset_d;
        end
    end

    assign link_mode = link_mode_q;
    assign primary_tx_enable = primary_tx_q;
    assign secondary_tx_enable = secondary_tx_q;
    assign secondary_back_channel_enable = back_channel_q;
    assign pixel_split_enable = split_q;
    assign tx_clock_half_rate = split_q;
    assign shared_protection_session = shared_prot_q;
    assign second_protection_core_enable = second_core_q;
    assign pixel_clock_over_limit = over_q;
    assign serial_pll_reset = pll_reset_q;

    // remote lookup falls back to the internal sram copy when nothing answers
    assign use_remote_display_id = !display_id_source_select && remote_display_id_found;
    assign use_external_local_display_id = display_id_source_select;
    assign remote_display_id_address = display_id_address_q;
    assign copy_remote_to_sram = copy_sel && remote_display_id_found;
    assign aux_audio_enable = bridge_configuration_q[BIT_AUDIO_AUX];
    assign external_controller_override = bridge_configuration_q[BIT_EXTERNAL_CONTROL];
    assign cable_type_select = dual_link_control_q[BIT_COAXIAL_CABLE];
endmodule

// >>> testbench/slmc_strap_link_config_props.sv
`timescale 1ns/100ps
module slmc_strap_link_config_props (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] prdata,
    input wire logic pslverr,
    input wire logic freq_change_detected,
    input wire logic remote_display_id_found,
    input wire logic rx0_present,
    input wire logic rx1_present,
    input wire logic use_remote_display_id,
    input wire logic use_external_local_display_id,
    input wire logic copy_remote_to_sram,
    input wire logic aux_audio_enable,
    input wire logic external_controller_override,
    input wire logic cable_type_select,
    input wire logic [1:0] link_mode,
    input wire logic primary_tx_enable,
    input wire logic secondary_tx_enable,
    input wire logic pixel_split_enable,
    input wire logic tx_clock_half_rate,
    input wire logic shared_protection_session,
    input wire logic second_protection_core_enable,
    input wire logic serial_pll_reset
);
    // cycles since reset release; the strap load lands at 500, just before 505
    logic [9:0] up_q;
    logic [9:0] up_d;
    assign up_d = (up_q == 10'h3ff) ? up_q : up_q + 10'h1;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            up_q <= 10'h0;
        end else begin
            up_q <= up_d;
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_slverr_phase: assert property (pslverr |-> psel && penable)
        else $error("slave error outside access phase");
    a_refused_read: assert property (pslverr && !pwrite |-> prdata == 32'h0)
        else $error("refused read returned data");
    a_copy_gate: assert property (copy_remote_to_sram |-> remote_display_id_found)
        else $error("copy requested without remote display id");
    a_source_excl: assert property (use_remote_display_id |-> !use_external_local_display_id)
        else $error("remote and external local display id both selected");
    a_pll_pulse: assert property (serial_pll_reset |-> $past(freq_change_detected))
        else $error("pll reset without frequency change");
    a_dual_split: assert property (link_mode == 2'h1 |-> pixel_split_enable && tx_clock_half_rate
        && shared_protection_session) else $error("dual link without split, half rate or shared session");
    a_replicate_cores: assert property (link_mode == 2'h2 |-> second_protection_core_enable
        && primary_tx_enable && secondary_tx_enable) else $error("replicate without both links and cores");
    a_secondary_alone: assert property (link_mode == 2'h3 |-> $past(rx1_present && !rx0_present, 2)
        && secondary_tx_enable && !primary_tx_enable) else $error("secondary only mode without cause");
    a_option_hold: assert property ((up_q > 10'd505) && ($changed(aux_audio_enable)
        || $changed(external_controller_override) || $changed(cable_type_select))
        |-> $past(psel && penable && pwrite)) else $error("option bit changed without a write");
endmodule
bind slmc_strap_link_config slmc_strap_link_config_props i_props (.*);

// >>> testbench/slmc_far_side.sv
`timescale 1ns/100ps
module slmc_far_side (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [3:0] cap,
    input wire logic [7:0] mhz,
    input wire logic kick,
    input wire logic want_found,
    output logic rx0_present,
    output logic rx1_present,
    output logic rx0_dual_capable,
    output logic rx0_legacy,
    output logic [7:0] pixel_clock_mhz,
    output logic freq_change_detected,
    output logic remote_display_id_found
);
    logic kick_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            {rx0_present, rx1_present, rx0_dual_capable, rx0_legacy} <= 4'h0;
            pixel_clock_mhz <= 8'h0;
            kick_q <= 1'b0;
            freq_change_detected <= 1'b0;
            remote_display_id_found <= 1'b0;
        end else begin
            // capability bits only mean something while a primary receiver answers
            {rx0_present, rx1_present, rx0_dual_capable, rx0_legacy} <= {cap[3:2], cap[3] & cap[1], cap[3] & cap[0]};
            pixel_clock_mhz <= mhz;
            kick_q <= kick;
            freq_change_detected <= kick && !kick_q;
            remote_display_id_found <= want_found && cap[3];
        end
    end
endmodule

// >>> testbench/slmc_strap_link_config_tb.sv
`timescale 1ns/100ps
module slmc_strap_link_config_tb;
    import slmc_pkg::*;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel, penable, pwrite, pready, pslverr, er, kick, want_found;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [7:0] first_config_strap, second_config_strap, pixel_clock_mhz, remote_display_id_address, mhz, rnd;
    logic rx0_present, rx1_present, rx0_dual_capable, rx0_legacy, freq_change_detected, remote_display_id_found;
    logic use_remote_display_id, use_external_local_display_id, copy_remote_to_sram, aux_audio_enable;
    logic external_controller_override, cable_type_select, primary_tx_enable, secondary_tx_enable;
    logic secondary_back_channel_enable, pixel_split_enable, tx_clock_half_rate, shared_protection_session;
    logic second_protection_core_enable, serial_pll_reset, pixel_clock_over_limit;
    logic [1:0] link_mode, s0;
    logic [2:0] s1;
    logic [3:0] cap;
    int failures = 0;
    int checks = 0;
    int hits;
    localparam logic [7:0] S0_CODE [4] = '{8'h00, 8'h35, 8'h8d, 8'haa};
    localparam logic [7:0] S1_CODE [8] = '{8'h00, 8'h35, 8'h52, 8'h70, 8'h8d, 8'haa, 8'hc9, 8'hff};
    localparam logic [11:0] HAND [9] = '{12'hc55, 12'hc56, 12'h43c, 12'ha61, 12'haab, 12'ha60, 12'h861, 12'h955,
        12'h954};
    localparam logic [11:0] A_CTL = {IDX_BRIDGE_CONTROL, 2'b00};
    localparam logic [11:0] A_CFG = {IDX_BRIDGE_CONFIGURATION, 2'b00};
    localparam logic [11:0] A_DUAL = {IDX_DUAL_LINK_CONTROL, 2'b00};
    localparam logic [11:0] A_ID = {IDX_DISPLAY_ID_ADDRESS, 2'b00};
    always #10 pclk = ~pclk;
    slmc_strap_link_config i_dut (.*);
    slmc_far_side i_far (.*);
    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction
    function automatic logic [31:0] exp_cfg(input logic [1:0] a, input logic [2:0] b);
        return {24'h0, b[2], 1'b0, b[0], 3'h0, a[0], 1'b0};
    endfunction
    function automatic logic [2:0] exp_link(input logic [3:0] c, input logic [7:0] f);
        logic [1:0] m;
        m = (c[3] && c[2]) ? 2'h2 : c[2] ? 2'h3 : (c[3] && c[1] && f >= 8'd97) ? 2'h1 : 2'h0;
        if (m == 2'h2) begin
            return {f > 8'd85, m};
        end
        if (m == 2'h1) begin
            return {f > 8'd170, m};
        end
        return {c[0] ? f >= 8'd85 : f > 8'd96, m};
    endfunction
    task automatic wrap_up;
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            failures++;
            $display("mismatch at %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            failures++;
            wrap_up();
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wait_n(input int k);
        repeat (k) @(posedge pclk);
        #1;
    endtask
    task automatic pll_hits;
        kick <= 1'b1;
        hits = 0;
        repeat (8) begin
            @(posedge pclk);
            #1;
            if (serial_pll_reset !== 1'b0) hits++;
        end
        kick = 1'b0;
    endtask
    initial begin
        {psel, penable, pwrite, kick, want_found} = 5'h0;
        paddr = 12'h0;
        pwdata = 32'h0;
        {first_config_strap, second_config_strap} = 16'h0;
        cap = 4'h8;
        mhz = 8'd60;
        rnd = 8'd90;
        for (int i = 0; i < 8; i++) begin
            rnd = lfsr(rnd);
            s0 = rnd[1:0];
            s1 = 3'(i);
            @(posedge pclk);
            presetn <= 1'b0;
            first_config_strap <= S0_CODE[s0];
            second_config_strap <= S1_CODE[s1];
            repeat (5) @(posedge pclk);
            presetn <= 1'b1;
            apb(1'b0, A_DUAL, 32'h0);
            chk(rd, 32'h20);
            wait_n(505);
            apb(1'b0, A_CTL, 32'h0);
            chk(rd, {31'h0, s0[1]});
            apb(1'b0, A_CFG, 32'h0);
            chk(rd, exp_cfg(s0, s1));
            apb(1'b0, A_DUAL, 32'h0);
            chk(rd, {24'h0, s1[1], 7'h20});
            chk({28'h0, aux_audio_enable, use_external_local_display_id, external_controller_override,
                cable_type_select}, {28'h0, s0[0], s0[1], s1[2], s1[1]});
            first_config_strap <= rnd;
            second_config_strap <= ~rnd;
            wait_n(4);
            apb(1'b0, A_CFG, 32'h0);
            chk(rd, exp_cfg(s0, s1));
            $display("strap pass %0d done", i);
        end
        rnd = lfsr(rnd);
        apb(1'b1, A_CTL, {24'h0, rnd});
        apb(1'b0, A_CTL, 32'h0);
        chk(rd, {24'h0, rnd});
        apb(1'b1, A_CFG, {24'h0, ~rnd});
        wait_n(2);
        chk({30'h0, aux_audio_enable, external_controller_override}, {30'h0, ~rnd[1], ~rnd[7]});
        apb(1'b1, 12'h3fc, 32'hffffffff);
        chk({31'h0, er}, 32'h1);
        apb(1'b0, 12'h3fc, 32'h0);
        chk({rd[30:0], er}, 32'h1);
        apb(1'b0, A_ID, 32'h0);
        chk({rd[23:0], remote_display_id_address}, 32'ha0a0);
        apb(1'b1, A_CTL, 32'h0);
        apb(1'b1, A_CFG, 32'h20);
        want_found <= 1'b1;
        wait_n(4);
        chk({29'h0, copy_remote_to_sram, use_remote_display_id, use_external_local_display_id}, 32'h6);
        want_found = 1'b0;
        wait_n(4);
        chk({31'h0, copy_remote_to_sram}, 32'h0);
        $display("register test done");
        apb(1'b1, A_DUAL, 32'h20);
        for (int j = 0; j < 17; j++) begin
            if (j < 9) begin
                {cap, mhz} = HAND[j];
            end else begin
                rnd = lfsr(rnd);
                mhz = rnd;
                rnd = lfsr(rnd);
                cap = {1'b1, rnd[2:0]};
            end
            wait_n(6);
            chk({29'h0, pixel_clock_over_limit, link_mode}, {29'h0, exp_link(cap, mhz)});
        end
        cap = 4'hc;
        mhz = 8'd60;
        apb(1'b1, A_DUAL, 32'h21);
        wait_n(4);
        chk({28'h0, link_mode, secondary_tx_enable, secondary_back_channel_enable}, 32'h0);
        apb(1'b1, A_DUAL, 32'h23);
        wait_n(4);
        chk({27'h0, link_mode, pixel_split_enable, tx_clock_half_rate, shared_protection_session}, 32'hf);
        apb(1'b1, A_DUAL, 32'h25);
        wait_n(4);
        chk({29'h0, link_mode, second_protection_core_enable}, 32'h5);
        $display("link mode test done");
        apb(1'b1, A_DUAL, 32'h20);
        pll_hits();
        chk(32'(hits), 32'h1);
        apb(1'b1, A_DUAL, 32'h00);
        pll_hits();
        chk(32'(hits), 32'h0);
        $display("pll reset test done");
        wrap_up();
    end
endmodule
